// >>> hdl/dnrm_regs.svh
// dnrm_regs.svh - offsets, ranges, scale factors and timing of the drive register map
// assumes inclusion by the design modules only
`ifndef DNRM_REGS_SVH
`define DNRM_REGS_SVH
`define DNRM_ADDR_BASE 16'h9c41
`define DNRM_OFS_FREQ_CMD 16'h0002
`define DNRM_OFS_STATE 16'h0003
`define DNRM_OFS_FB_IN 16'h0005
`define DNRM_OFS_OUT_FREQ 16'h1002
`define DNRM_OFS_CURRENT 16'h1003
`define DNRM_OFS_DIR 16'h1004
`define DNRM_OFS_FB_MON_HI 16'h1005
`define DNRM_OFS_FB_MON_LO 16'h1006
`define DNRM_OFS_IN_TERM 16'h1007
`define DNRM_OFS_OUT_TERM 16'h1008
`define DNRM_OFS_SFREQ_HI 16'h1009
`define DNRM_OFS_SFREQ_LO 16'h100a
`define DNRM_OFS_VOLT 16'h100c
`define DNRM_OFS_RUN_HI 16'h100e
`define DNRM_OFS_RUN_LO 16'h100f
`define DNRM_OFS_PON_HI 16'h1010
`define DNRM_OFS_PON_LO 16'h1011
`define DNRM_PAIR_FB 0
`define DNRM_PAIR_SFREQ 1
`define DNRM_PAIR_RUN 2
`define DNRM_PAIR_PON 3
`define DNRM_FREQ_MAX 16'h0fa0
`define DNRM_STATE_MAX 16'h0009
`define DNRM_FB_MAX 16'h03e8
`define DNRM_MON_MAX 24'h0f423f
`define DNRM_NET_DIV 16'h000a
`define DNRM_FB_MON_DIV 24'h00000a
`define DNRM_SRC_NET_FREQ 2'h3
`define DNRM_SRC_NET_FB 2'h2
`define DNRM_EXC_NONE 8'h00
`define DNRM_EXC_ADDR 8'h02
`define DNRM_EXC_DATA 8'h03
`define DNRM_CLK_HZ 10000000
`define DNRM_SEC_PER_HOUR 3600
`define DNRM_FILT_TAU_MS 100
`define DNRM_FILT_STEP_MS 1
`define DNRM_FILT_FRAC 8
`endif

// >>> hdl/dnrm_pkg.sv
// dnrm_pkg.sv - types shared by the drive register map modules
// assumes dnrm_regs.svh sits on the include path
package dnrm_pkg;
  typedef enum logic [3:0] {
    DS_INITIAL,
    DS_RESERVED,
    DS_STOP,
    DS_RUN,
    DS_COAST_STOP,
    DS_JOGGING,
    DS_DC_BRAKING,
    DS_RETRY,
    DS_TRIP_ALARM,
    DS_UNDERVOLTAGE
  } dnrm_drive_state_t;
endpackage

// >>> hdl/dnrm_hour_counter.sv
// dnrm_hour_counter.sv - whole-hour counter that saturates at the monitor ceiling
// assumes count_en_in is synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "dnrm_regs.svh"
module dnrm_hour_counter #(
  parameter int unsigned SEC_CYCLES = `DNRM_CLK_HZ
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic count_en_in,
  output logic [19:0] hours_out
);
  localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);
  localparam logic [11:0] HOUR_LAST = 12'(`DNRM_SEC_PER_HOUR - 1);
  logic [23:0] cyc_q;
  logic [11:0] sec_q;
  logic [19:0] hours_q;
  // partial hours are kept while paused, so time in run mode adds up exactly
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cyc_q <= 24'h000000;
      sec_q <= 12'h000;
      hours_q <= 20'h00000;
    end else if (count_en_in) begin
      cyc_q <= (cyc_q == SEC_LAST) ? 24'h000000 : cyc_q + 24'h000001;
      if (cyc_q == SEC_LAST) begin
        sec_q <= (sec_q == HOUR_LAST) ? 12'h000 : sec_q + 12'h001;
        if (sec_q == HOUR_LAST && hours_q != 20'(`DNRM_MON_MAX)) begin
          hours_q <= hours_q + 20'h00001;
        end
      end
    end
  end
  assign hours_out = hours_q;
endmodule
`default_nettype wire

// >>> hdl/dnrm_current_filter.sv
// dnrm_current_filter.sv - first-order low-pass on the current sample
// assumes sample_in is synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "dnrm_regs.svh"
module dnrm_current_filter #(
  parameter int unsigned STEP_CYCLES = `DNRM_CLK_HZ / 1000 * `DNRM_FILT_STEP_MS
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [10:0] sample_in,
  output logic [10:0] filtered_out
);
  localparam logic [18:0] RATIO = 19'(`DNRM_FILT_TAU_MS / `DNRM_FILT_STEP_MS);
  localparam logic [13:0] STEP_LAST = 14'(STEP_CYCLES - 1);
  logic [13:0] tick_q;
  logic [18:0] acc_q;
  logic [18:0] target;
  // fraction bits keep the small steps of a slow time constant from vanishing
  assign target = {sample_in, 8'h00};
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      tick_q <= 14'h0000;
      acc_q <= 19'h00000;
    end else begin
      tick_q <= (tick_q == STEP_LAST) ? 14'h0000 : tick_q + 14'h0001;
      if (tick_q == STEP_LAST) begin
        if (target >= acc_q) begin
          acc_q <= acc_q + (target - acc_q) / RATIO;
        end else begin
          acc_q <= acc_q - (acc_q - target) / RATIO;
        end
      end
    end
  end
  assign filtered_out = acc_q[18:`DNRM_FILT_FRAC];
endmodule
`default_nettype wire

// >>> hdl/dnrm_register_map.sv
// dnrm_register_map.sv - network holding-register bank of the motor drive
// assumes one request per cycle from the frame layer, same clock as sys_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "dnrm_regs.svh"
module dnrm_register_map #(
  parameter int unsigned SEC_CYCLES = `DNRM_CLK_HZ,
  parameter int unsigned FILT_STEP_CYCLES = `DNRM_CLK_HZ / 1000 * `DNRM_FILT_STEP_MS
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic reg_ack_out,
  output logic [7:0] reg_exc_out,
  output logic [15:0] reg_rdata_out,
  input wire logic [1:0] frequency_source_select_in,
  input wire logic [1:0] feedback_source_select_in,
  input wire logic [13:0] feedback_scale_constant_in,
  input wire logic [9:0] frequency_display_constant_in,
  input wire dnrm_pkg::dnrm_drive_state_t drive_state_in,
  input wire logic drive_running_in,
  input wire logic [11:0] out_freq_in,
  input wire logic [10:0] current_sample_in,
  input wire logic [1:0] direction_in,
  input wire logic [9:0] process_feedback_value_in,
  input wire logic [4:0] input_terminal_pins_in,
  input wire logic [2:0] output_terminal_state_in,
  input wire logic [14:0] output_voltage_in,
  output logic freq_cmd_valid_out,
  output logic [11:0] freq_cmd_out,
  output logic [8:0] freq_cmd_hz_out,
  output logic fb_net_valid_out,
  output logic [9:0] fb_net_out,
  output logic [6:0] fb_net_pct_out,
  output dnrm_pkg::dnrm_drive_state_t drive_state_code_out
);
  logic [15:0] rel;
  logic wr_take;
  logic rd_take;
  logic [15:0] rd_val;
  logic rd_ok;
  logic [3:0] pair_hi;
  logic [3:0] pair_lo;
  logic [7:0] wr_exc;
  logic [31:0] pair_val [4];
  logic [15:0] lo_val [4];
  logic [11:0] freq_cmd_q;
  logic [8:0] freq_hz_q;
  logic freq_valid_q;
  logic [9:0] fb_net_q;
  logic [6:0] fb_pct_q;
  logic fb_valid_q;
  dnrm_pkg::dnrm_drive_state_t state_q;
  dnrm_pkg::dnrm_drive_state_t hw_prev_q;
  logic ack_q;
  logic [7:0] exc_q;
  logic [15:0] rdata_q;
  logic [11:0] mon_freq_q;
  logic [1:0] mon_dir_q;
  logic [14:0] mon_volt_q;
  logic [2:0] out_term_q;
  logic [4:0] in_term_q;
  logic [19:0] fb_mon_q;
  logic [19:0] sfreq_q;
  logic [23:0] fb_prod;
  logic [23:0] sfreq_prod;
  logic [9:0] fb_src;
  logic [10:0] cur_filt;
  logic [19:0] run_hours;
  logic [19:0] pon_hours;
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;

  // the host adds the offset to the base; the same base is stripped here
  assign rel = reg_addr_in - `DNRM_ADDR_BASE;
  // a write and a read in one cycle: the write is served
  assign wr_take = reg_wr_in;
  assign rd_take = reg_rd_in && !reg_wr_in;

  always_comb begin
    rd_val = 16'h0000;
    rd_ok = 1'b1;
    pair_hi = 4'h0;
    pair_lo = 4'h0;
    case (rel)
      `DNRM_OFS_FREQ_CMD: rd_val = {4'h0, freq_cmd_q};
      `DNRM_OFS_STATE: rd_val = {12'h000, state_q};
      `DNRM_OFS_FB_IN: rd_val = {6'h00, fb_net_q};
      `DNRM_OFS_OUT_FREQ: rd_val = {4'h0, mon_freq_q};
      `DNRM_OFS_CURRENT: rd_val = {5'h00, cur_filt};
      `DNRM_OFS_DIR: rd_val = {14'h0000, mon_dir_q};
      `DNRM_OFS_IN_TERM: rd_val = {11'h000, in_term_q};
      `DNRM_OFS_OUT_TERM: rd_val = {13'h0000, out_term_q};
      `DNRM_OFS_VOLT: rd_val = {1'b0, mon_volt_q};
      `DNRM_OFS_FB_MON_HI: begin
        rd_val = pair_val[`DNRM_PAIR_FB][31:16];
        pair_hi[`DNRM_PAIR_FB] = 1'b1;
      end
      `DNRM_OFS_FB_MON_LO: begin
        rd_val = lo_val[`DNRM_PAIR_FB];
        pair_lo[`DNRM_PAIR_FB] = 1'b1;
      end
      `DNRM_OFS_SFREQ_HI: begin
        rd_val = pair_val[`DNRM_PAIR_SFREQ][31:16];
        pair_hi[`DNRM_PAIR_SFREQ] = 1'b1;
      end
      `DNRM_OFS_SFREQ_LO: begin
        rd_val = lo_val[`DNRM_PAIR_SFREQ];
        pair_lo[`DNRM_PAIR_SFREQ] = 1'b1;
      end
      `DNRM_OFS_RUN_HI: begin
        rd_val = pair_val[`DNRM_PAIR_RUN][31:16];
        pair_hi[`DNRM_PAIR_RUN] = 1'b1;
      end
      `DNRM_OFS_RUN_LO: begin
        rd_val = lo_val[`DNRM_PAIR_RUN];
        pair_lo[`DNRM_PAIR_RUN] = 1'b1;
      end
      `DNRM_OFS_PON_HI: begin
        rd_val = pair_val[`DNRM_PAIR_PON][31:16];
        pair_hi[`DNRM_PAIR_PON] = 1'b1;
      end
      `DNRM_OFS_PON_LO: begin
        rd_val = lo_val[`DNRM_PAIR_PON];
        pair_lo[`DNRM_PAIR_PON] = 1'b1;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // only three registers accept data, each within its network range
  always_comb begin
    wr_exc = `DNRM_EXC_NONE;
    case (rel)
      `DNRM_OFS_FREQ_CMD: if (reg_wdata_in > `DNRM_FREQ_MAX) wr_exc = `DNRM_EXC_DATA;
      `DNRM_OFS_STATE: if (reg_wdata_in > `DNRM_STATE_MAX) wr_exc = `DNRM_EXC_DATA;
      `DNRM_OFS_FB_IN: if (reg_wdata_in > `DNRM_FB_MAX) wr_exc = `DNRM_EXC_DATA;
      default: wr_exc = `DNRM_EXC_ADDR;
    endcase
    // an undervoltage drive takes no new data
    if (wr_exc == `DNRM_EXC_NONE && state_q == dnrm_pkg::DS_UNDERVOLTAGE) begin
      wr_exc = `DNRM_EXC_DATA;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
      exc_q <= `DNRM_EXC_NONE;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= wr_take || rd_take;
      if (wr_take) begin
        exc_q <= wr_exc;
        rdata_q <= 16'h0000;
      end else if (rd_take) begin
        exc_q <= rd_ok ? `DNRM_EXC_NONE : `DNRM_EXC_ADDR;
        rdata_q <= rd_ok ? rd_val : 16'h0000;
      end else begin
        exc_q <= `DNRM_EXC_NONE;
        rdata_q <= 16'h0000;
      end
    end
  end

  // plain flops with no backing store: a power cycle brings back zeros
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      freq_cmd_q <= 12'h000;
      fb_net_q <= 10'h000;
    end else if (wr_take && wr_exc == `DNRM_EXC_NONE) begin
      if (rel == `DNRM_OFS_FREQ_CMD) freq_cmd_q <= reg_wdata_in[11:0];
      if (rel == `DNRM_OFS_FB_IN) fb_net_q <= reg_wdata_in[9:0];
    end
  end

  // whole units for internal use; the 0.1 step stays visible on the raw ports
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      freq_hz_q <= 9'h000;
      fb_pct_q <= 7'h00;
      freq_valid_q <= 1'b0;
      fb_valid_q <= 1'b0;
    end else begin
      freq_hz_q <= 9'(freq_cmd_q / `DNRM_NET_DIV);
      fb_pct_q <= 7'(fb_net_q / `DNRM_NET_DIV);
      freq_valid_q <= frequency_source_select_in == `DNRM_SRC_NET_FREQ;
      fb_valid_q <= feedback_source_select_in == `DNRM_SRC_NET_FB;
    end
  end

  // a change reported by the drive wins over a host write in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_q <= dnrm_pkg::DS_INITIAL;
      hw_prev_q <= dnrm_pkg::DS_INITIAL;
    end else begin
      hw_prev_q <= drive_state_in;
      if (drive_state_in != hw_prev_q) begin
        state_q <= drive_state_in;
      end else if (wr_take && wr_exc == `DNRM_EXC_NONE && rel == `DNRM_OFS_STATE) begin
        state_q <= dnrm_pkg::dnrm_drive_state_t'(reg_wdata_in[3:0]);
      end
    end
  end

  assign fb_src = fb_valid_q ? fb_net_q : process_feedback_value_in;
  // operands widened first so the product keeps its upper bits
  assign fb_prod = (24'(fb_src) * 24'(feedback_scale_constant_in)) / `DNRM_FB_MON_DIV;
  assign sfreq_prod = 24'(out_freq_in) * 24'(frequency_display_constant_in);

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      mon_freq_q <= 12'h000;
      mon_dir_q <= 2'h0;
      mon_volt_q <= 15'h0000;
      out_term_q <= 3'h0;
      fb_mon_q <= 20'h00000;
      sfreq_q <= 20'h00000;
    end else begin
      mon_freq_q <= out_freq_in;
      mon_dir_q <= direction_in;
      mon_volt_q <= output_voltage_in;
      out_term_q <= output_terminal_state_in;
      fb_mon_q <= fb_prod[19:0];
      // the product can pass the display ceiling, so it is held there
      sfreq_q <= (sfreq_prod > `DNRM_MON_MAX) ? 20'(`DNRM_MON_MAX) : sfreq_prod[19:0];
    end
  end

  // a terminal change counts only once the last two stages agree
  genvar gb;
  generate
    for (gb = 0; gb < 5; gb++) begin : g_term
      always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
          s1_q[gb] <= 1'b0;
          s2_q[gb] <= 1'b0;
          s3_q[gb] <= 1'b0;
          in_term_q[gb] <= 1'b0;
        end else begin
          s1_q[gb] <= input_terminal_pins_in[gb];
          s2_q[gb] <= s1_q[gb];
          s3_q[gb] <= s2_q[gb];
          if (s2_q[gb] == s3_q[gb]) in_term_q[gb] <= s3_q[gb];
        end
      end
    end
  endgenerate

  assign pair_val[`DNRM_PAIR_FB] = {12'h000, fb_mon_q};
  assign pair_val[`DNRM_PAIR_SFREQ] = {12'h000, sfreq_q};
  assign pair_val[`DNRM_PAIR_RUN] = {12'h000, run_hours};
  assign pair_val[`DNRM_PAIR_PON] = {12'h000, pon_hours};

  // reading the high word freezes the low word until the low word is read
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pair
      logic [15:0] shadow_q;
      logic armed_q;
      always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
          shadow_q <= 16'h0000;
          armed_q <= 1'b0;
        end else if (rd_take && pair_hi[gp]) begin
          shadow_q <= pair_val[gp][15:0];
          armed_q <= 1'b1;
        end else if (rd_take && pair_lo[gp]) begin
          armed_q <= 1'b0;
        end
      end
      assign lo_val[gp] = armed_q ? shadow_q : pair_val[gp][15:0];
    end
  endgenerate

  dnrm_hour_counter #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_run_hours (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .count_en_in(drive_running_in),
    .hours_out(run_hours)
  );

  dnrm_hour_counter #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_pon_hours (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .count_en_in(1'b1),
    .hours_out(pon_hours)
  );

  dnrm_current_filter #(
    .STEP_CYCLES(FILT_STEP_CYCLES)
  ) u_cur_filt (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .sample_in(current_sample_in),
    .filtered_out(cur_filt)
  );

  assign reg_ack_out = ack_q;
  assign reg_exc_out = exc_q;
  assign reg_rdata_out = rdata_q;
  assign freq_cmd_valid_out = freq_valid_q;
  assign freq_cmd_out = freq_cmd_q;
  assign freq_cmd_hz_out = freq_hz_q;
  assign fb_net_valid_out = fb_valid_q;
  assign fb_net_out = fb_net_q;
  assign fb_net_pct_out = fb_pct_q;
  assign drive_state_code_out = state_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  ack_timing_a: assert property (
    (reg_rd_in || reg_wr_in) |=> reg_ack_out ##1 !reg_ack_out || $past(reg_rd_in || reg_wr_in)
  ) else $error("request not answered in one cycle");

  freq_write_a: assert property (
    reg_wr_in && reg_addr_in == `DNRM_ADDR_BASE + `DNRM_OFS_FREQ_CMD
      && reg_wdata_in <= `DNRM_FREQ_MAX && state_q != dnrm_pkg::DS_UNDERVOLTAGE
    |=> freq_cmd_out == $past(reg_wdata_in[11:0]) && reg_exc_out == `DNRM_EXC_NONE
  ) else $error("legal frequency write not stored");

  ro_refuse_a: assert property (
    reg_wr_in && reg_addr_in == `DNRM_ADDR_BASE + `DNRM_OFS_OUT_FREQ
    |=> reg_ack_out && reg_exc_out == `DNRM_EXC_ADDR
  ) else $error("write to monitor not refused");

  range_refuse_a: assert property (
    reg_wr_in && reg_addr_in == `DNRM_ADDR_BASE + `DNRM_OFS_FB_IN && reg_wdata_in > `DNRM_FB_MAX
    |=> reg_exc_out == `DNRM_EXC_DATA && $stable(fb_net_out)
  ) else $error("out of range feedback write taken");

  source_gate_a: assert property (
    fb_net_valid_out |-> $past(feedback_source_select_in) == `DNRM_SRC_NET_FB
  ) else $error("feedback input valid without network source");

  hz_scale_a: assert property (
    freq_cmd_hz_out == 9'($past(freq_cmd_out) / `DNRM_NET_DIV)
  ) else $error("whole hertz value not command over ten");

  state_range_a: assert property (
    drive_state_code_out <= dnrm_pkg::DS_UNDERVOLTAGE
  ) else $error("drive state code out of range");

  pair_coherent_a: assert property (
    rd_take && rel == `DNRM_OFS_FB_MON_HI ##1 rd_take && rel == `DNRM_OFS_FB_MON_LO
    |=> reg_rdata_out == $past(fb_mon_q[15:0], 2)
  ) else $error("low word not from same sample as high word");

  term_agree_a: assert property (
    $changed(in_term_q) |-> $past(s2_q) == $past(s3_q) || $past(s2_q) != $past(s3_q, 2)
  ) else $error("terminal state changed before stages agreed");

  scaled_clamp_a: assert property (
    sfreq_q <= 20'(`DNRM_MON_MAX) && run_hours <= 20'(`DNRM_MON_MAX)
  ) else $error("monitor above ceiling");

  freq_write_c: cover property (reg_wr_in && rel == `DNRM_OFS_FREQ_CMD ##1 freq_cmd_valid_out);
  ro_write_c: cover property (reg_ack_out && reg_exc_out == `DNRM_EXC_ADDR);
  pair_read_c: cover property (rd_take && pair_hi != 4'h0 ##[1:4] rd_take && pair_lo != 4'h0);
  state_hw_c: cover property (drive_state_in != hw_prev_q && wr_take);
endmodule
`default_nettype wire

// >>> testbench/dnrm_host_model.sv
// dnrm_host_model.sv - network host that issues single register reads and writes
// assumes the answer is registered on the taking edge and read just after it, on the same clock
`timescale 1ns/1ps
`default_nettype none
module dnrm_host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [7:0] exc_in,
  input wire logic [15:0] rdata_in,
  output logic rd_out,
  output logic wr_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end

  // one pulse per request; address is base plus offset, formed by the caller
  // write data is already scaled into the register's integer range
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
      output logic [7:0] exc, output logic [15:0] rdata, output logic hung);
    hung = 1'b1;
    exc = 8'h00;
    rdata = 16'h0000;
    @(posedge clk_in);
    #1;
    rd_out = ~w;
    wr_out = w;
    addr_out = a;
    wdata_out = w ? d : ~d;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    wr_out = 1'b0;
    // released lines must not keep the last value, so invert them
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
    for (int i = 0; i < 4 && hung; i++) begin
      if (ack_in === 1'b1) begin
        hung = 1'b0;
        exc = exc_in;
        rdata = rdata_in;
      end else begin
        @(posedge clk_in);
        #1;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// testbench.sv - scenario tasks for the drive holding-register bank
// assumes short second and filter step parameters so hour counts fit the run
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HOUR = 3600 * 4;
  localparam logic [15:0] B = 16'h9c41;
  logic clk = 1'b0, rstn = 1'b0, running = 1'b0;
  logic [1:0] fsrc = 2'h3, bsrc = 2'h2, dir = 2'h0;
  logic [13:0] scale = 14'h0001;
  logic [9:0] disp = 10'h001, pfb = 10'h000;
  logic [11:0] ofreq = 12'h000;
  logic [10:0] cur = 11'h000;
  logic [4:0] pins = 5'h00;
  logic [2:0] oterm = 3'h0;
  logic [14:0] volt = 15'h0000;
  dnrm_pkg::dnrm_drive_state_t state = dnrm_pkg::DS_INITIAL;
  dnrm_pkg::dnrm_drive_state_t sc;
  logic rd, wr, ack, fcv, bv;
  logic [15:0] addr, wdata, rdata, rv;
  logic [7:0] exc;
  logic [11:0] fc;
  logic [8:0] fhz;
  logic [9:0] bn;
  logic [6:0] bp;
  int err_count = 0, compares = 0, cyc = 0;

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= rstn ? cyc + 1 : 0;

  dnrm_host_model host (.clk_in(clk), .ack_in(ack), .exc_in(exc), .rdata_in(rdata),
    .rd_out(rd), .wr_out(wr), .addr_out(addr), .wdata_out(wdata));

  dnrm_register_map #(.SEC_CYCLES(4), .FILT_STEP_CYCLES(4)) dut (
    .sys_clk_in(clk), .rstn_in(rstn), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_ack_out(ack), .reg_exc_out(exc),
    .reg_rdata_out(rdata), .frequency_source_select_in(fsrc),
    .feedback_source_select_in(bsrc), .feedback_scale_constant_in(scale),
    .frequency_display_constant_in(disp), .drive_state_in(state),
    .drive_running_in(running), .out_freq_in(ofreq), .current_sample_in(cur),
    .direction_in(dir), .process_feedback_value_in(pfb), .input_terminal_pins_in(pins),
    .output_terminal_state_in(oterm), .output_voltage_in(volt),
    .freq_cmd_valid_out(fcv), .freq_cmd_out(fc), .freq_cmd_hz_out(fhz),
    .fb_net_valid_out(bv), .fb_net_out(bn), .fb_net_pct_out(bp),
    .drive_state_code_out(sc));

  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one access; exception code judged, read data left in rv
  task automatic acc_any(input logic w, input logic [15:0] a, input logic [15:0] d,
      input logic [7:0] xe);
    logic [7:0] x;
    logic h;
    host.access(w, a, d, x, rv, h);
    chk({31'h0, h}, 32'h0);
    if (h === 1'b1)
      results();
    chk({24'h0, x}, {24'h0, xe});
  endtask

  // one access; exception code and read data both judged
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
      input logic [7:0] xe, input logic [15:0] re);
    acc_any(w, a, d, xe);
    chk({16'h0, rv}, {16'h0, re});
  endtask

  task automatic t_reset;
    chk({20'h0, fc}, 32'h0);
    chk({28'h0, sc}, 32'h0);
    acc(1'b0, B + 16'h0002, 16'h0000, 8'h00, 16'h0000);
  endtask

  task automatic t_freq;
    acc(1'b1, B + 16'h0002, 16'h0fa0, 8'h00, 16'h0000);
    chk({20'h0, fc}, 32'h0fa0);
    tick(1);
    chk({23'h0, fhz}, 32'h0190);
    acc(1'b1, B + 16'h0002, 16'h0fa1, 8'h03, 16'h0000);
    acc(1'b0, B + 16'h0002, 16'h0000, 8'h00, 16'h0fa0);
    chk({31'h0, fcv}, 32'h1);
    fsrc = 2'h0;
    tick(2);
    chk({31'h0, fcv}, 32'h0);
  endtask

  task automatic t_fb;
    acc(1'b1, B + 16'h0005, 16'h03e8, 8'h00, 16'h0000);
    tick(1);
    chk({25'h0, bp}, 32'h64);
    acc(1'b1, B + 16'h0005, 16'h03e9, 8'h03, 16'h0000);
    acc(1'b0, B + 16'h0005, 16'h0000, 8'h00, 16'h03e8);
    chk({31'h0, bv}, 32'h1);
    bsrc = 2'h0;
    tick(2);
    chk({31'h0, bv}, 32'h0);
  endtask

  task automatic t_access;
    logic [15:0] ro [14] = '{16'h1002, 16'h1003, 16'h1004, 16'h1005, 16'h1006, 16'h1007,
      16'h1008, 16'h1009, 16'h100a, 16'h100c, 16'h100e, 16'h100f, 16'h1010, 16'h1011};
    foreach (ro[i])
      acc(1'b1, B + ro[i], 16'h0001, 8'h02, 16'h0000);
    acc(1'b0, B + 16'h0004, 16'h0000, 8'h02, 16'h0000);
    acc(1'b0, 16'h1002, 16'h0000, 8'h02, 16'h0000);
  endtask

  task automatic t_mon;
    ofreq = 12'hfa0;
    dir = 2'h2;
    volt = 15'h4e20;
    oterm = 3'h5;
    pins = 5'h15;
    tick(6);
    acc(1'b0, B + 16'h1002, 16'h0000, 8'h00, 16'h0fa0);
    acc(1'b0, B + 16'h1004, 16'h0000, 8'h00, 16'h0002);
    acc(1'b0, B + 16'h100c, 16'h0000, 8'h00, 16'h4e20);
    acc(1'b0, B + 16'h1008, 16'h0000, 8'h00, 16'h0005);
    acc(1'b0, B + 16'h1007, 16'h0000, 8'h00, 16'h0015);
  endtask

  // step response of the current filter: about 63 percent after one time constant
  task automatic t_cur;
    cur = 11'h7d0;
    tick(400);
    acc_any(1'b0, B + 16'h1003, 16'h0000, 8'h00);
    chk({31'h0, rv >= 16'd1150 && rv <= 16'd1380}, 32'h1);
    tick(3600);
    acc_any(1'b0, B + 16'h1003, 16'h0000, 8'h00);
    chk({31'h0, rv >= 16'd1990 && rv <= 16'd2000}, 32'h1);
  endtask

  task automatic t_pair;
    ofreq = 12'h4d2;
    disp = 10'h1f4;
    pfb = 10'h3e8;
    scale = 14'h270f;
    tick(3);
    acc(1'b0, B + 16'h1009, 16'h0000, 8'h00, 16'h0009);
    ofreq = 12'h064;
    tick(3);
    acc(1'b0, B + 16'h100a, 16'h0000, 8'h00, 16'h6a28);
    acc(1'b0, B + 16'h100a, 16'h0000, 8'h00, 16'hc350);
    acc(1'b0, B + 16'h1005, 16'h0000, 8'h00, 16'h000f);
    acc(1'b0, B + 16'h1006, 16'h0000, 8'h00, 16'h41dc);
    ofreq = 12'hfa0;
    disp = 10'h3e7;
    tick(3);
    acc(1'b0, B + 16'h1009, 16'h0000, 8'h00, 16'h000f);
    acc(1'b0, B + 16'h100a, 16'h0000, 8'h00, 16'h423f);
  endtask

  task automatic t_state;
    acc(1'b1, B + 16'h0003, 16'h000a, 8'h03, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      state = dnrm_pkg::dnrm_drive_state_t'(i);
      tick(3);
      acc(1'b0, B + 16'h0003, 16'h0000, 8'h00, 16'(i));
    end
    acc(1'b1, B + 16'h0003, 16'h0009, 8'h00, 16'h0000);
    acc(1'b0, B + 16'h0003, 16'h0000, 8'h00, 16'h0009);
    acc(1'b1, B + 16'h0002, 16'h0064, 8'h03, 16'h0000);
    state = dnrm_pkg::DS_STOP;
    tick(3);
    acc(1'b0, B + 16'h0003, 16'h0000, 8'h00, 16'h0002);
  endtask

  // run for an hour and a half inside a window of two and a half hours since reset
  task automatic t_hours;
    running = 1'b1;
    tick(HOUR + HOUR / 2);
    running = 1'b0;
    while (cyc < 5 * HOUR / 2)
      tick(1);
    acc(1'b0, B + 16'h1010, 16'h0000, 8'h00, 16'h0000);
    acc(1'b0, B + 16'h1011, 16'h0000, 8'h00, 16'h0002);
    acc(1'b0, B + 16'h100e, 16'h0000, 8'h00, 16'h0000);
    acc_any(1'b0, B + 16'h100f, 16'h0000, 8'h00);
    chk({31'h0, rv == 16'h0001 || rv == 16'h0002}, 32'h1);
  endtask

  initial begin
    tick(10);
    rstn = 1'b1;
    t_reset();
    t_freq();
    t_fb();
    t_access();
    t_mon();
    t_cur();
    t_pair();
    t_state();
    t_hours();
    results();
  end
endmodule
`default_nettype wire
